// ==== logic/card_punch_serial_buffer_path.sv ====
`timescale 1ns/1ns
// Function
// - punch command: fill buffer from processor, punch card, stack it, read next card
// - punch: channel end after last byte, device end after punch and next read
// - punch accepted without error gives all-zero initial status
// - intervention required gives unit check, status bit 6, at initial selection
// - equipment check during punch gives unit check with device end
// - one shared data line; strobe stays high for a whole column
// - while strobe is high, emit exactly twelve shift clock pulses
// - serial register is three chained 4-bit right-shift stages
// - serial register shifts right on every falling shift clock edge
// - strobe fall while reading loads twelve serial bits into the buffer
// - strobe rise while punching loads one buffer column into the serial register
// - buffer is a static 12-bit shift structure up to 100 ranks deep
// - buffer input takes processor data while filling, serial data otherwise (reading and punch recirculation)
// - each load shifts ranks by one; rank 80 or 96 (by card length) recirculates through the serial register when punching, always visible
// - invalid char when more than one of buffer bits 1 to 7 is set
// - invalid char sets data check only during ebcdic read
// - card code converted to ebcdic on bus-in input 0, ebcdic reads only
// - card image read sends each column as two bytes in bits 2-7
// - equipment check from error line; reject and data check from decode and tags
// - any sense flag setting also sets unit check, except during sense
// - three status flip-flops (unit check, channel end and device end pending); the sequencer sets feed request
// - shift clock has a one microsecond period
// - card_in_read_station active: receive data; inactive: drive punch data

////////////////////////////////////////////////////////////////////////////////
module byte_fifo #(
	parameter int WIDTH = card_punch_pkg::FIFO_WIDTH,
	parameter int DEPTH = card_punch_pkg::FIFO_DEPTH
) (
	input  wire logic             clk_sys,
	input  wire logic             rst_n,
	input  wire logic             clk_en,
	input  wire logic             in_valid,
	output logic                  in_ready,
	input  wire logic [WIDTH-1:0] in_data,
	output logic                  out_valid,
	input  wire logic             out_ready,
	output logic      [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [0:DEPTH-1];
	logic [AW-1:0]    wptr;
	logic [AW-1:0]    rptr;
	logic [AW:0]      count;
	logic [AW:0]      next_count;
	logic             push;
	logic             pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_depth_check
		$error("fifo depth must be a power of two, at least two");
	end

	// handshakes qualified by registered full and empty
	assign push = in_valid && in_ready;
	assign pop  = out_valid && out_ready;
	assign out_data = mem[rptr];

	always_comb begin
		next_count = count;
		if (push && !pop) begin
			next_count = count + 1'b1;
		end else if (pop && !push) begin
			next_count = count - 1'b1;
		end
	end

	// storage has no reset; pointers, count and the ready/valid flags carry control state
	always_ff @(posedge clk_sys) begin
		if (clk_en && push) begin
			mem[wptr] <= in_data;
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			wptr      <= '0;
			rptr      <= '0;
			count     <= '0;
			in_ready  <= 1'b0;
			out_valid <= 1'b0;
		end else if (clk_en) begin
			if (push) wptr <= wptr + 1'b1;
			if (pop) rptr <= rptr + 1'b1;
			count     <= next_count;
			in_ready  <= next_count != (AW+1)'(DEPTH);
			out_valid <= next_count != '0;
		end
	end
endmodule : byte_fifo

////////////////////////////////////////////////////////////////////////////////
module card_punch_serial_buffer_path #(
	parameter int RANKS = card_punch_pkg::BUFFER_RANKS
) (
	input  wire logic       clk_sys,
	input  wire logic       rst_n,
	input  wire logic       clk_en,
	// reader/punch pins
	input  wire logic       strobe_in,
	input  wire logic       card_in_read_station,
	input  wire logic       data_in,
	output logic            data_out,
	output logic            data_oe,
	output logic            shift_clk,
	input  wire logic       error_in,
	input  wire logic       ready_in,
	output logic            feed_req,
	output logic            offset_req,
	// command side
	input  wire logic       cmd_valid,
	input  wire logic [1:0] cmd_op,
	input  wire logic       cmd_image,
	input  wire logic       cmd_stacker,
	input  wire logic       cmd_reject_cond,
	input  wire logic       cols96,
	output logic            status_valid,
	output logic      [7:0] status_byte,
	output logic      [1:0] status_kind,
	// processor data toward the punch
	input  wire logic       wr_valid,
	output logic            wr_ready,
	input  wire logic [7:0] wr_data,
	// bus-in toward the processor
	output logic            rd_valid,
	input  wire logic       rd_ready,
	output logic      [7:0] rd_data,
	output logic            invalid_char_flag
);
	if (RANKS < card_punch_pkg::COLS_LONG_CARD || RANKS > card_punch_pkg::BUFFER_RANKS) begin : g_ranks_check
		$error("buffer ranks must hold a long card and not exceed the documented depth");
	end

	// card code rows: bit 0 row 0, bits 1..9 rows 1..9, bit 10 row 11, bit 11 row 12
	function automatic logic [7:0] card_to_ebcdic(input logic [11:0] c);
		logic [3:0] digit;
		logic [3:0] zone;
		digit = 4'h0;
		for (int i = 1; i <= 7; i++) begin
			if (c[i]) digit = 4'(i);
		end
		if (c[8]) digit = digit + 4'h8;
		if (c[9]) digit = 4'h9;
		zone = c[11] ? 4'hc : c[10] ? 4'hd : (c[0] && digit != 4'h0) ? 4'he : 4'hf;
		if (c == 12'h000) begin
			card_to_ebcdic = 8'h40;
		end else begin
			card_to_ebcdic = {zone, digit};
		end
	endfunction : card_to_ebcdic

	function automatic logic [11:0] ebcdic_to_card(input logic [7:0] e);
		logic [11:0] c;
		c = 12'h000;
		case (e[7:4])
			4'hc: c[11] = 1'b1;
			4'hd: c[10] = 1'b1;
			4'he: c[0] = 1'b1;
			default: c = 12'h000;
		endcase
		if (e[3:0] == 4'h0 && e[7:4] == 4'hf) c[0] = 1'b1;
		if (e[3:0] >= 4'h8 && e[3:0] != 4'h9) c[8] = 1'b1;
		if (e[3:0] == 4'h9) c[9] = 1'b1;
		if (e[3:0] != 4'h0 && e[3:0] != 4'h8 && e[3:0] != 4'h9) c[4'(e[2:0])] = 1'b1;
		if (e == 8'h40) c = 12'h000;
		ebcdic_to_card = c;
	endfunction : ebcdic_to_card

	////////////////////////////////////////////////////////////////////////
	// pin resynchronisers
	logic [4:0] sync_a;
	logic [4:0] sync_b;
	logic       strobe_q;
	logic       strobe_s;
	logic       present_s;
	logic       data_s;
	logic       error_s;
	logic       ready_s;

	assign strobe_s  = sync_b[0];
	assign present_s = sync_b[1];
	assign data_s    = sync_b[2];
	assign error_s   = sync_b[3];
	assign ready_s   = sync_b[4];

	// two stages before any logic looks at a pin
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			sync_a   <= '0;
			sync_b   <= '0;
			strobe_q <= 1'b0;
		end else if (clk_en) begin
			sync_a   <= {ready_in, error_in, data_in, card_in_read_station, strobe_in};
			sync_b   <= sync_a;
			strobe_q <= strobe_s;
		end
	end

	logic strobe_rise;
	logic strobe_fall;
	assign strobe_rise = strobe_s && !strobe_q;
	assign strobe_fall = !strobe_s && strobe_q;

	////////////////////////////////////////////////////////////////////////
	// shift clock generator and serial column register
	localparam int HALF = card_punch_pkg::SHIFT_HALF_CYCLES;
	logic [7:0]  half_cnt;
	logic [3:0]  pulses;
	logic [11:0] serial_col;
	logic        clk_fall;
	logic        gen_on;
	logic        punching;
	logic [11:0] buf_out;
	localparam card_punch_pkg::op_state_t S_IDLE = card_punch_pkg::S_IDLE, S_FILL = card_punch_pkg::S_FILL,
		S_PUNCH = card_punch_pkg::S_PUNCH, S_READ = card_punch_pkg::S_READ,
		S_CHAN_RD = card_punch_pkg::S_CHAN_RD, S_SENSE = card_punch_pkg::S_SENSE;

	assign gen_on   = strobe_s && pulses != 4'(card_punch_pkg::BITS_PER_COLUMN);
	assign clk_fall = shift_clk && half_cnt == 8'(HALF - 1);
	assign punching = !present_s;

	// one microsecond clock, low between columns
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			half_cnt  <= '0;
			shift_clk <= 1'b0;
			pulses    <= '0;
		end else if (clk_en) begin
			if (strobe_rise) begin
				pulses   <= '0;
				half_cnt <= '0;
			end else if (gen_on || shift_clk) begin
				if (half_cnt == 8'(HALF - 1)) begin
					half_cnt  <= '0;
					shift_clk <= !shift_clk;
					if (shift_clk) pulses <= pulses + 4'h1;
				end else begin
					half_cnt <= half_cnt + 8'h01;
				end
			end
		end
	end

	// three 4-bit stages chained, serial input at the top
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			serial_col <= card_punch_pkg::COLUMN_RESET;
		end else if (clk_en) begin
			if (strobe_rise && punching) begin
				serial_col <= buf_out;
			end else if (clk_fall) begin
				serial_col <= {data_s, serial_col[11:1]};
			end
		end
	end

	// transmitter off while a card is in the read station
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			data_out <= 1'b0;
			data_oe  <= 1'b0;
		end else if (clk_en) begin
			data_out <= serial_col[0];
			data_oe  <= punching;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// static shift buffer
	card_punch_pkg::op_state_t state;
	logic [11:0] bufr [0:RANKS-1];
	logic        buf_shift;
	logic [11:0] buf_in;
	logic [11:0] punch_col;
	logic [6:0]  ncols;
	logic        pop_now;
	logic        rd_take;
	logic        image;
	logic        second_half;
	logic [5:0]  first_half;
	logic        fifo_valid;
	logic [7:0]  fifo_data;

	assign ncols   = cols96 ? 7'(card_punch_pkg::COLS_LONG_CARD) : 7'(card_punch_pkg::COLS_SHORT_CARD);
	assign buf_out = bufr[ncols - 7'h01];
	assign rd_take = rd_valid && rd_ready;
	assign pop_now = state == S_FILL && fifo_valid;

	// processor bytes become card columns: one ebcdic byte or two image halves
	assign punch_col = image ? {first_half, fifo_data[5:0]} : ebcdic_to_card(fifo_data);

	// input select: serial data when reading, processor data when filling
	assign buf_in = state == S_FILL ? punch_col : serial_col;

	// one shift per column, whoever moves the column
	assign buf_shift = (strobe_fall && present_s && state != S_CHAN_RD)
		|| (strobe_rise && punching && state == S_PUNCH)
		|| (pop_now && (!image || second_half))
		|| (rd_take && state == S_CHAN_RD && (!image || second_half));

	// no reset: contents are data, held until shifted out
	always_ff @(posedge clk_sys) begin
		if (clk_en && buf_shift) begin
			bufr[0] <= buf_in;
			for (int i = 1; i < RANKS; i++) begin
				bufr[i] <= bufr[i-1];
			end
		end
	end

	// incoming bytes wait here so the channel never outruns the buffer fill
	byte_fifo #(
		.WIDTH (card_punch_pkg::FIFO_WIDTH),
		.DEPTH (card_punch_pkg::FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.rst_n     (rst_n),
		.clk_en    (clk_en),
		.in_valid  (wr_valid && state == S_FILL),
		.in_ready  (wr_ready),
		.in_data   (wr_data),
		.out_valid (fifo_valid),
		.out_ready (state == S_FILL),
		.out_data  (fifo_data)
	);

	////////////////////////////////////////////////////////////////////////
	// character check and sense flags
	logic invalid_now;
	logic reject_ff;
	logic interv_ff;
	logic equip_ff;
	logic dcheck_ff;
	logic set_reject;
	logic set_interv;
	logic set_equip;
	logic set_dcheck;
	logic cmd_take;

	assign invalid_now = $countones(buf_out[7:1]) > 1;
	assign cmd_take    = cmd_valid && state == S_IDLE;
	assign set_reject  = cmd_take && cmd_reject_cond;
	assign set_interv  = cmd_take && !ready_s && cmd_op != card_punch_pkg::OP_SENSE;
	assign set_equip   = error_s && (state == S_PUNCH || state == S_READ);
	assign set_dcheck  = rd_take && state == S_CHAN_RD && !image && invalid_now;

	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			invalid_char_flag <= 1'b0;
		end else if (clk_en) begin
			invalid_char_flag <= invalid_now;
		end
	end

	// sense clears on the sense byte taken; a set in that cycle wins
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			reject_ff <= 1'b0;
			interv_ff <= 1'b0;
			equip_ff  <= 1'b0;
			dcheck_ff <= 1'b0;
		end else if (clk_en) begin
			if (rd_take && state == S_SENSE) begin
				reject_ff <= 1'b0;
				interv_ff <= 1'b0;
				equip_ff  <= 1'b0;
				dcheck_ff <= 1'b0;
			end
			if (set_reject) reject_ff <= 1'b1;
			if (set_interv) interv_ff <= 1'b1;
			if (set_equip) equip_ff <= 1'b1;
			if (set_dcheck) dcheck_ff <= 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// status flip-flops and operation sequencer
	logic       unit_check;
	logic       device_end_pend;
	logic       channel_end_pend;
	logic [6:0] col_cnt;
	logic       cmd_error;
	logic       any_sense_set;

	assign any_sense_set = set_reject || set_interv || set_equip || set_dcheck;
	assign cmd_error     = cmd_reject_cond || (!ready_s && cmd_op != card_punch_pkg::OP_SENSE);

	// unit check follows any sense set unless a sense op runs
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			unit_check <= 1'b0;
		end else if (clk_en) begin
			if (status_valid && status_byte[1]) unit_check <= 1'b0;
			if (any_sense_set && state != S_SENSE && !(cmd_take && cmd_op == card_punch_pkg::OP_SENSE)) begin
				unit_check <= 1'b1;
			end
		end
	end

	// main sequence: fill, punch, read next card, report
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			state            <= S_IDLE;
			col_cnt          <= '0;
			image            <= 1'b0;
			second_half      <= 1'b0;
			first_half       <= '0;
			feed_req         <= 1'b0;
			offset_req       <= 1'b0;
			device_end_pend  <= 1'b0;
			channel_end_pend <= 1'b0;
			status_valid     <= 1'b0;
			status_byte      <= card_punch_pkg::BYTE_RESET;
			status_kind      <= card_punch_pkg::KIND_INITIAL;
		end else if (clk_en) begin
			status_valid <= 1'b0;
			case (state)
				S_IDLE: begin
					if (cmd_take) begin
						col_cnt      <= '0;
						second_half  <= 1'b0;
						image        <= cmd_image;
						offset_req   <= cmd_stacker;
						status_valid <= 1'b1;
						status_kind  <= card_punch_pkg::KIND_INITIAL;
						status_byte  <= card_punch_pkg::BYTE_RESET;
						if (cmd_error) begin
							status_byte <= card_punch_pkg::ST_UNIT_CHECK;
						end else begin
							case (cmd_op)
								card_punch_pkg::OP_PUNCH: state <= S_FILL;
								card_punch_pkg::OP_READ:  state <= S_CHAN_RD;
								card_punch_pkg::OP_SENSE: state <= S_SENSE;
								default: status_byte <= card_punch_pkg::ST_CHANNEL_END | card_punch_pkg::ST_DEVICE_END;
							endcase
						end
					end
				end
				S_FILL: begin
					if (pop_now) begin
						second_half <= image && !second_half;
						first_half  <= fifo_data[5:0];
						if (!image || second_half) begin
							col_cnt <= col_cnt + 7'h01;
							if (col_cnt == ncols - 7'h01) begin
								col_cnt          <= '0;
								state            <= S_PUNCH;
								feed_req         <= 1'b1;
								channel_end_pend <= 1'b1;
								status_valid     <= 1'b1;
								status_kind      <= card_punch_pkg::KIND_ENDING;
								status_byte      <= card_punch_pkg::ST_CHANNEL_END;
							end
						end
					end
				end
				S_PUNCH: begin
					if (strobe_fall && punching) begin
						col_cnt <= col_cnt + 7'h01;
						if (col_cnt == ncols - 7'h01) begin
							col_cnt <= '0;
							state   <= S_READ;
						end
					end
				end
				S_READ: begin
					if (strobe_fall && present_s) begin
						col_cnt <= col_cnt + 7'h01;
						if (col_cnt == ncols - 7'h01) begin
							col_cnt          <= '0;
							state            <= S_IDLE;
							feed_req         <= 1'b0;
							channel_end_pend <= 1'b0;
							device_end_pend  <= 1'b0;
							status_valid     <= 1'b1;
							status_kind      <= card_punch_pkg::KIND_ASYNC;
							status_byte      <= card_punch_pkg::ST_DEVICE_END
								| ((equip_ff || set_equip) ? card_punch_pkg::ST_UNIT_CHECK : 8'h00);
						end
					end
				end
				S_CHAN_RD: begin
					if (rd_take) begin
						second_half <= image && !second_half;
						if (!image || second_half) begin
							col_cnt <= col_cnt + 7'h01;
							if (col_cnt == ncols - 7'h01) begin
								col_cnt         <= '0;
								state           <= S_READ;
								feed_req        <= 1'b1;
								device_end_pend <= 1'b1;
								status_valid    <= 1'b1;
								status_kind     <= card_punch_pkg::KIND_ENDING;
								status_byte     <= card_punch_pkg::ST_CHANNEL_END
									| ((dcheck_ff || set_dcheck) ? card_punch_pkg::ST_UNIT_CHECK : 8'h00);
							end
						end
					end
				end
				S_SENSE: begin
					if (rd_take) begin
						state        <= S_IDLE;
						status_valid <= 1'b1;
						status_kind  <= card_punch_pkg::KIND_ENDING;
						status_byte  <= card_punch_pkg::ST_CHANNEL_END | card_punch_pkg::ST_DEVICE_END;
					end
				end
				default: state <= S_IDLE;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// bus-in selector: input 0 ebcdic, inputs 1 and 2 card image, sense
	logic [7:0] next_rd_data;
	always_comb begin
		next_rd_data = 8'h00;
		if (state == S_SENSE) begin
			next_rd_data = (reject_ff ? card_punch_pkg::SN_CMD_REJECT : 8'h00)
				| (interv_ff ? card_punch_pkg::SN_INTERV_REQ : 8'h00)
				| (equip_ff ? card_punch_pkg::SN_EQUIP_CHECK : 8'h00)
				| (dcheck_ff ? card_punch_pkg::SN_DATA_CHECK : 8'h00);
		end else if (!image) begin
			next_rd_data = card_to_ebcdic(buf_out);
		end else if (!second_half) begin
			next_rd_data = {2'b00, buf_out[11:6]};
		end else begin
			next_rd_data = {2'b00, buf_out[5:0]};
		end
	end

	// registered so data stands with valid; dropped one cycle after each take
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rd_valid <= 1'b0;
			rd_data  <= card_punch_pkg::BYTE_RESET;
		end else if (clk_en) begin
			if (rd_take) begin
				rd_valid <= 1'b0;
			end else if (state == S_CHAN_RD || state == S_SENSE) begin
				rd_valid <= 1'b1;
				rd_data  <= next_rd_data;
			end
		end
	end
endmodule : card_punch_serial_buffer_path

// ==== logic/card_punch_pkg.sv ====
package card_punch_pkg;
	// link timing: shift clock period and system clock period
	localparam int SHIFT_CLK_PERIOD_NS = 1000;
	localparam int SYS_CLK_PERIOD_NS   = 4;
	localparam int SHIFT_HALF_CYCLES   = SHIFT_CLK_PERIOD_NS / (2 * SYS_CLK_PERIOD_NS);
	localparam int BITS_PER_COLUMN     = 12;
	localparam int BUFFER_RANKS        = 100;
	localparam int COLS_SHORT_CARD     = 80;
	localparam int COLS_LONG_CARD      = 96;
	localparam int FIFO_WIDTH          = 8;
	localparam int FIFO_DEPTH          = 16;

	// command codes on cmd_op
	localparam logic [1:0] OP_PUNCH = 2'h0;
	localparam logic [1:0] OP_READ  = 2'h1;
	localparam logic [1:0] OP_SENSE = 2'h2;
	localparam logic [1:0] OP_NOP   = 2'h3;

	// status byte, bit 0 is the msb
	localparam logic [7:0] ST_BUSY        = 8'h10;
	localparam logic [7:0] ST_CHANNEL_END = 8'h08;
	localparam logic [7:0] ST_DEVICE_END  = 8'h04;
	localparam logic [7:0] ST_UNIT_CHECK  = 8'h02;

	// sense byte
	localparam logic [7:0] SN_CMD_REJECT  = 8'h80;
	localparam logic [7:0] SN_INTERV_REQ  = 8'h40;
	localparam logic [7:0] SN_EQUIP_CHECK = 8'h10;
	localparam logic [7:0] SN_DATA_CHECK  = 8'h08;

	// status_kind codes
	localparam logic [1:0] KIND_INITIAL = 2'h0;
	localparam logic [1:0] KIND_ENDING  = 2'h1;
	localparam logic [1:0] KIND_ASYNC   = 2'h2;

	// reset values
	localparam logic [11:0] COLUMN_RESET = 12'h000;
	localparam logic [7:0]  BYTE_RESET   = 8'h00;

	typedef enum logic [5:0] {
		S_IDLE    = 6'b000001,
		S_FILL    = 6'b000010,
		S_PUNCH   = 6'b000100,
		S_READ    = 6'b001000,
		S_CHAN_RD = 6'b010000,
		S_SENSE   = 6'b100000
	} op_state_t;
endpackage : card_punch_pkg

// ==== verification/card_punch_props.sv ====
`timescale 1ns/1ns
module card_punch_props #(
	parameter int RANKS = card_punch_pkg::BUFFER_RANKS
) (
	input wire logic       clk_sys,
	input wire logic       rst_n,
	input wire logic       strobe_in,
	input wire logic       card_in_read_station,
	input wire logic       shift_clk,
	input wire logic       data_oe,
	input wire logic       ready_in,
	input wire logic       cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic       cmd_reject_cond,
	input wire logic       status_valid,
	input wire logic [7:0] status_byte,
	input wire logic [1:0] status_kind
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	logic       sc_d;
	logic       st_d;
	logic [3:0] pc;
	logic [7:0] hc;
	wire        init_st = status_valid && status_kind == card_punch_pkg::KIND_INITIAL;
	wire        punch   = cmd_valid && cmd_op == card_punch_pkg::OP_PUNCH;
	// pulses since strobe rose; cycles since shift clock last moved
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			{sc_d, st_d, pc, hc} <= '0;
		end else begin
			sc_d <= shift_clk;
			st_d <= strobe_in;
			pc   <= (strobe_in && !st_d) ? 4'h0 : pc + 4'(shift_clk && !sc_d);
			hc   <= (shift_clk != sc_d) ? 8'h00 : hc + 8'h01;
		end
	end
	// ready level must settle through the pin synchronisers first
	sequence s_ready;
		ready_in [*4];
	endsequence
	sequence s_unready;
		!ready_in [*4];
	endsequence
	a_status_one_cycle: assert property (status_valid |=> !status_valid)
		else $error("status held too long");
	a_punch_zero_status: assert property (s_ready ##0 punch && !cmd_reject_cond |=> !init_st || status_byte == 8'h00)
		else $error("punch status not zero");
	a_unready_unit_check: assert property (s_unready ##0 punch |=> !init_st || status_byte == 8'h02)
		else $error("no unit check when not ready");
	a_reject_unit_check: assert property (cmd_valid && cmd_reject_cond && cmd_op != card_punch_pkg::OP_SENSE
		|=> !init_st || status_byte == card_punch_pkg::ST_UNIT_CHECK) else $error("no unit check on reject");
	a_clock_idle_low: assert property (!strobe_in [*8] |-> !shift_clk) else $error("shift clock outside column");
	a_twelve_pulses: assert property ($fell(strobe_in) |-> pc == 4'hc) else $error("pulse count wrong");
	a_half_period: assert property ($fell(shift_clk) |-> hc == 8'h7c) else $error("shift clock high time wrong");
	a_oe_follows_card: assert property ($stable(card_in_read_station) [*6]
		|-> data_oe == !card_in_read_station) else $error("driver enable wrong");
endmodule : card_punch_props
////////////////////////////////////////
bind card_punch_serial_buffer_path card_punch_props #(.RANKS(RANKS)) i_card_punch_props (
	.clk_sys, .rst_n, .strobe_in, .card_in_read_station, .shift_clk, .data_oe, .ready_in,
	.cmd_valid, .cmd_op, .cmd_reject_cond, .status_valid, .status_byte, .status_kind
);

// ==== verification/card_mech_model.sv ====
`timescale 1ns/1ns
module card_mech_model (
	input  wire logic shift_clk,
	input  wire logic data_line,
	output logic      strobe,
	output logic      card_in_read_station,
	output logic      drv
);
	logic lk;
	logic act;
	// own 32 ns clock, phase unrelated to the system clock
	initial begin
		{lk, act, strobe, card_in_read_station, drv} = '0;
		#7;
		forever #16 lk = ~lk;
	end
	// released line keeps changing so no stale bit is read
	always @(posedge lk) if (!act) drv = ~drv;
	// one column: strobe held over all twelve bits, dropped after the last
	task automatic column(input logic rd, input logic [11:0] v, output int p, output logic [11:0] got);
		logic s;
		int   n;
		{p, s, got} = '0;
		card_in_read_station = rd;
		act = rd;
		repeat (4) @(posedge lk);
		strobe = 1;
		for (n = 0; n < 600 && p < 12; n++) begin
			@(posedge lk);
			// punch bits taken while clock is high; the adapter shifts on the fall
			if (shift_clk && !s) begin
				if (rd) drv = v[p];
				else got = {data_line, got[11:1]};
			end
			if (!shift_clk && s) p++;
			s = shift_clk;
		end
		strobe = 0;
	endtask : column
endmodule : card_mech_model

// ==== verification/test_card_punch_serial_buffer_path.sv ====
`timescale 1ns/1ns
module test_card_punch_serial_buffer_path;
	logic        clk_sys = 0;
	logic        rst_n = 0;
	logic        strobe_in;
	logic        card_in_read_station;
	logic        drv;
	logic        data_out;
	logic        data_oe;
	logic        shift_clk;
	logic        ready_in = 1;
	logic        feed_req;
	logic        offset_req;
	logic        cmd_valid = 0;
	logic [1:0]  cmd_op = '0;
	logic        cmd_stacker = 0;
	logic        cmd_image = 0;
	logic        cmd_reject_cond = 0;
	logic        status_valid;
	logic [7:0]  status_byte;
	logic [1:0]  status_kind;
	logic        wr_valid = 0;
	logic        wr_ready;
	logic [7:0]  wr_data = '0;
	logic        rd_valid;
	logic        rd_ready = 0;
	logic [7:0]  rd_data;
	logic        invalid_char_flag;
	logic [9:0]  stq[$];
	logic [9:0]  rdq[$];
	logic [7:0]  wq[$];
	logic [11:0] got;
	int          num_errors = 0;
	int          n_tests = 0;
	int          seed = 36;
	int          p;
	int          i;
	wire         data_wire = data_oe ? data_out : drv;
	card_punch_serial_buffer_path i_card_punch_serial_buffer_path (
		.clk_sys, .rst_n, .clk_en(1'b1), .strobe_in, .card_in_read_station, .data_in(data_wire),
		.data_out, .data_oe, .shift_clk, .error_in(1'b0), .ready_in, .feed_req, .offset_req,
		.cmd_valid, .cmd_op, .cmd_image, .cmd_stacker, .cmd_reject_cond, .cols96(1'b0),
		.status_valid, .status_byte, .status_kind, .wr_valid, .wr_ready, .wr_data,
		.rd_valid, .rd_ready, .rd_data, .invalid_char_flag
	);
	card_mech_model i_card_mech_model (
		.shift_clk, .data_line(data_wire), .strobe(strobe_in), .card_in_read_station, .drv
	);
	// system clock
	initial begin
		forever #2 clk_sys = ~clk_sys;
	end
	// log statuses and taken bytes; channel stalls most cycles
	always @(posedge clk_sys) begin
		if (status_valid) stq.push_back({status_kind, status_byte});
		if (rd_valid && rd_ready) rdq.push_back({2'h0, rd_data});
		rd_ready <= #1 ($random(seed) & 3) == 0;
	end
	task automatic check(input logic [9:0] seen, input logic [9:0] exp);
		n_tests++;
		if (seen !== exp) begin
			num_errors++;
			$display("wrong value at %0t ns: got %h, want %h", $time, seen, exp);
		end
	endtask : check
	task automatic give_verdict;
		if (num_errors == 0 && n_tests > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask : give_verdict
	// bounded wait for the next logged item
	task automatic expect_q(ref logic [9:0] q[$], input logic [9:0] exp);
		int n;
		for (n = 0; n < 3000 && q.size() == 0; n++) @(posedge clk_sys) #1;
		if (q.size() == 0) begin
			num_errors++;
			give_verdict();
		end else check(q.pop_front(), exp);
	endtask : expect_q
	task automatic command(input logic [1:0] op, input logic rej);
		@(posedge clk_sys) #1;
		cmd_valid = 1;
		cmd_op = op;
		cmd_reject_cond = rej;
		cmd_stacker = 1'($random(seed));
		@(posedge clk_sys) #1;
		cmd_valid = 0;
	endtask : command
	task automatic sense(input logic [7:0] flags);
		command(card_punch_pkg::OP_SENSE, 0);
		expect_q(stq, 10'h000);
		expect_q(rdq, {2'h0, flags});
		expect_q(stq, {card_punch_pkg::KIND_ENDING, card_punch_pkg::ST_CHANNEL_END | card_punch_pkg::ST_DEVICE_END});
	endtask : sense
	// main sequence
	initial begin
		repeat (4) @(posedge clk_sys);
		#1 rst_n = 1;
		repeat (2) @(posedge clk_sys); // ready reads low until the synchronisers fill
		command(card_punch_pkg::OP_NOP, 1);
		expect_q(stq, {card_punch_pkg::KIND_INITIAL, card_punch_pkg::ST_UNIT_CHECK});
		sense(card_punch_pkg::SN_CMD_REJECT);
		ready_in = 0;
		repeat (4) @(posedge clk_sys) #1;
		command(card_punch_pkg::OP_PUNCH, 0);
		expect_q(stq, {card_punch_pkg::KIND_INITIAL, card_punch_pkg::ST_UNIT_CHECK});
		ready_in = 1;
		repeat (4) @(posedge clk_sys) #1;
		sense(card_punch_pkg::SN_INTERV_REQ);
		// punch: a full card image, two bytes per column
		cmd_image = 1;
		command(card_punch_pkg::OP_PUNCH, 0);
		expect_q(stq, 10'h000);
		check({9'h0, offset_req}, {9'h0, cmd_stacker});
		for (i = 0; i < 2 * card_punch_pkg::COLS_SHORT_CARD; i++) begin
			wr_data = 8'($random(seed));
			wq.push_back(wr_data);
			wr_valid = 1;
			for (p = 0; p < 99 && !wr_ready; p++) @(posedge clk_sys) #1;
			if (!wr_ready) begin
				num_errors++;
				give_verdict();
			end
			@(posedge clk_sys) #1;
		end
		wr_valid = 0;
		expect_q(stq, {card_punch_pkg::KIND_ENDING, card_punch_pkg::ST_CHANNEL_END});
		@(posedge clk_sys) #1;
		check({9'h0, feed_req}, 10'h001);
		check({9'h0, invalid_char_flag}, {9'h0, $countones({wq[0][1:0], wq[1][5:1]}) > 1});
		// two columns punched out, then two read in
		for (i = 0; i < 4; i++) begin
			i_card_mech_model.column(i > 1, 12'($random(seed)), p, got);
			check(10'(p), 10'h00c);
			if (i < 2) check(10'(got[11:6]), 10'(wq[2*i][5:0]));
			if (i < 2) check(10'(got[5:0]), 10'(wq[2*i+1][5:0]));
			check({9'h0, data_oe}, {9'h0, i < 2});
		end
		give_verdict();
	end
endmodule : test_card_punch_serial_buffer_path
